// *** hdl/torque_limit_selector.sv ***
// Purpose: pick the active forward and reverse torque limits
// Assumes: pins and command frame fields arrive asynchronously and are synchronised here
// Notes: limits refresh one cycle after the synchronised inputs settle
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module torque_limit_selector (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // terminals and command frame
  input wire logic fwd_limit_pin,
  input wire logic rev_limit_pin,
  input wire logic [torque_limit_pkg::IO_W-1:0] cmd_io_field,
  input wire logic signed [torque_limit_pkg::LIM_W-1:0] cmd_torque_limit,
  input wire torque_limit_pkg::mode_t op_mode,
  // active limits
  output torque_limit_pkg::lim_pair_t active_limit
);
  logic [2:0] method;
  logic fwd_mapped;
  logic rev_mapped;
  torque_limit_pkg::lim_pair_t lim1;
  torque_limit_pkg::lim_pair_t lim2;
  logic [torque_limit_pkg::LIM_W-1:0] motor_max;

  logic fwd_pin_s1, fwd_pin_s2, rev_pin_s1, rev_pin_s2;
  logic [torque_limit_pkg::IO_W-1:0] io_s1, io_s2;
  logic [torque_limit_pkg::LIM_W-1:0] cmd_s1, cmd_s2;
  logic [1:0] mode_s1, mode_s2;

  logic fwd_limit_select;
  logic rev_limit_select;
  logic [torque_limit_pkg::LIM_W-1:0] cmd_mag;
  logic cmd_allowed;
  torque_limit_pkg::lim_pair_t next_limit;

  function automatic logic [torque_limit_pkg::LIM_W-1:0] min2(
    input logic [torque_limit_pkg::LIM_W-1:0] a,
    input logic [torque_limit_pkg::LIM_W-1:0] b
  );
    min2 = (a < b) ? a : b;
  endfunction

  // two-stage synchronisers; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_pin_s1 <= 1'b0;
      fwd_pin_s2 <= 1'b0;
      rev_pin_s1 <= 1'b0;
      rev_pin_s2 <= 1'b0;
      io_s1 <= '0;
      io_s2 <= '0;
      cmd_s1 <= '0;
      cmd_s2 <= '0;
      mode_s1 <= 2'h0;
      mode_s2 <= 2'h0;
    end else if (clk_en) begin
      fwd_pin_s1 <= fwd_limit_pin;
      fwd_pin_s2 <= fwd_pin_s1;
      rev_pin_s1 <= rev_limit_pin;
      rev_pin_s2 <= rev_pin_s1;
      io_s1 <= cmd_io_field;
      io_s2 <= io_s1;
      cmd_s1 <= cmd_torque_limit;
      cmd_s2 <= cmd_s1;
      mode_s1 <= op_mode;
      mode_s2 <= mode_s1;
    end
  end

  always_comb begin
    logic fwd_term;
    logic rev_term;
    logic use_lim2;
    logic use_cmd;
    logic cmd_gated;
    logic lim2_gated;
    logic [torque_limit_pkg::LIM_W-1:0] f;
    logic [torque_limit_pkg::LIM_W-1:0] r;
    fwd_term = fwd_pin_s2 & fwd_mapped;
    rev_term = rev_pin_s2 & rev_mapped;
    // an unmapped terminal reads as off; the command bit still counts
    fwd_limit_select = fwd_term | io_s2[torque_limit_pkg::IO_FWD_BIT];
    rev_limit_select = rev_term | io_s2[torque_limit_pkg::IO_REV_BIT];
    // most negative value saturates instead of wrapping
    if (cmd_s2[torque_limit_pkg::LIM_W-1]) begin
      cmd_mag = (cmd_s2 == 16'h8000) ? 16'h7FFF : 16'(-cmd_s2);
    end else begin
      cmd_mag = cmd_s2;
    end
    cmd_allowed = !(mode_s2[1] && mode_s2[0]);
    use_lim2 = (method == torque_limit_pkg::METH_LIM2_GATED) || (method == torque_limit_pkg::METH_BOTH_GATED);
    cmd_gated = (method == torque_limit_pkg::METH_CMD_GATED) || (method == torque_limit_pkg::METH_BOTH_GATED);
    lim2_gated = use_lim2;
    use_cmd = cmd_allowed && ((method == torque_limit_pkg::METH_CMD) || cmd_gated);
    f = lim1.fwd;
    r = lim1.rev;
    if (lim2_gated && fwd_limit_select) begin
      f = min2(f, lim2.fwd);
    end
    if (lim2_gated && rev_limit_select) begin
      r = min2(r, lim2.rev);
    end
    if (use_cmd) begin
      // gated command limit needs a mapped terminal per direction
      if (!cmd_gated || (fwd_mapped && fwd_limit_select)) begin
        f = min2(f, cmd_mag);
      end
      if (!cmd_gated || (rev_mapped && rev_limit_select)) begin
        r = min2(r, cmd_mag);
      end
    end
    next_limit.fwd = min2(f, motor_max);
    next_limit.rev = min2(r, motor_max);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_limit.fwd <= torque_limit_pkg::LIM_ZERO;
      active_limit.rev <= torque_limit_pkg::LIM_ZERO;
    end else if (clk_en) begin
      active_limit <= next_limit;
    end
  end

  // register writes take effect in the access phase; zero-wait slave
  logic wr_en;
  assign wr_en = psel && penable && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      method <= torque_limit_pkg::CTRL_RESET_METHOD;
      fwd_mapped <= 1'b0;
      rev_mapped <= 1'b0;
      lim1.fwd <= torque_limit_pkg::LIM_RESET_P1;
      lim1.rev <= torque_limit_pkg::LIM_RESET_N1;
      lim2.fwd <= torque_limit_pkg::LIM_RESET_P2;
      lim2.rev <= torque_limit_pkg::LIM_RESET_N2;
      motor_max <= torque_limit_pkg::LIM_RESET_MOTOR_MAX;
    end else if (clk_en && wr_en) begin
      if (paddr == torque_limit_pkg::ADDR_CTRL) begin
        method <= pwdata[torque_limit_pkg::CTRL_METHOD_LSB +: 3];
        fwd_mapped <= pwdata[torque_limit_pkg::CTRL_FWD_MAP_BIT];
        rev_mapped <= pwdata[torque_limit_pkg::CTRL_REV_MAP_BIT];
      end else if (paddr == torque_limit_pkg::ADDR_FWD_LIM1) begin
        lim1.fwd <= pwdata[torque_limit_pkg::LIM_W-1:0];
      end else if (paddr == torque_limit_pkg::ADDR_REV_LIM1) begin
        lim1.rev <= pwdata[torque_limit_pkg::LIM_W-1:0];
      end else if (paddr == torque_limit_pkg::ADDR_FWD_LIM2) begin
        lim2.fwd <= pwdata[torque_limit_pkg::LIM_W-1:0];
      end else if (paddr == torque_limit_pkg::ADDR_REV_LIM2) begin
        lim2.rev <= pwdata[torque_limit_pkg::LIM_W-1:0];
      end else if (paddr == torque_limit_pkg::ADDR_MOTOR_MAX) begin
        motor_max <= pwdata[torque_limit_pkg::LIM_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= torque_limit_pkg::DATA_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= torque_limit_pkg::DATA_ZERO;
      if (psel && !penable) begin
        if (paddr == torque_limit_pkg::ADDR_CTRL) begin
          prdata <= {26'h0, rev_mapped, fwd_mapped, 1'b0, method};
        end else if (paddr == torque_limit_pkg::ADDR_FWD_LIM1) begin
          prdata <= {16'h0, lim1.fwd};
        end else if (paddr == torque_limit_pkg::ADDR_REV_LIM1) begin
          prdata <= {16'h0, lim1.rev};
        end else if (paddr == torque_limit_pkg::ADDR_FWD_LIM2) begin
          prdata <= {16'h0, lim2.fwd};
        end else if (paddr == torque_limit_pkg::ADDR_REV_LIM2) begin
          prdata <= {16'h0, lim2.rev};
        end else if (paddr == torque_limit_pkg::ADDR_MOTOR_MAX) begin
          prdata <= {16'h0, motor_max};
        end else if (paddr == torque_limit_pkg::ADDR_STATUS) begin
          prdata <= {29'h0, cmd_allowed, rev_limit_select, fwd_limit_select};
        end else if (paddr == torque_limit_pkg::ADDR_ACTIVE) begin
          prdata <= active_limit;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule

// *** hdl/torque_limit_pkg.sv ***
// Purpose: shared constants, register map and carrier types of the torque limit selector
// Assumes: apb slave, 32-bit data, limits in percent of rated torque
// Notes: method code selects which limit sources take part
package torque_limit_pkg;
  localparam int LIM_W = 16;
  localparam logic [LIM_W-1:0] LIM_RESET_P1 = 16'h0320;
  localparam logic [LIM_W-1:0] LIM_RESET_N1 = 16'h0320;
  localparam logic [LIM_W-1:0] LIM_RESET_P2 = 16'h0064;
  localparam logic [LIM_W-1:0] LIM_RESET_N2 = 16'h0064;
  localparam logic [LIM_W-1:0] LIM_RESET_MOTOR_MAX = 16'h012C;
  localparam logic [LIM_W-1:0] LIM_ZERO = 16'h0000;
  localparam logic [LIM_W-1:0] LIM_MAX = 16'hFFFF;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FWD_LIM1 = 12'h004;
  localparam logic [11:0] ADDR_REV_LIM1 = 12'h008;
  localparam logic [11:0] ADDR_FWD_LIM2 = 12'h00C;
  localparam logic [11:0] ADDR_REV_LIM2 = 12'h010;
  localparam logic [11:0] ADDR_MOTOR_MAX = 12'h014;
  localparam logic [11:0] ADDR_STATUS = 12'h018;
  localparam logic [11:0] ADDR_ACTIVE = 12'h01C;

  // ctrl fields
  localparam int CTRL_METHOD_LSB = 0;
  localparam int CTRL_FWD_MAP_BIT = 4;
  localparam int CTRL_REV_MAP_BIT = 5;
  localparam logic [2:0] CTRL_RESET_METHOD = 3'h0;

  // io field bit positions of the command frame
  localparam int IO_FWD_BIT = 0;
  localparam int IO_REV_BIT = 1;
  localparam int IO_W = 16;

  localparam logic [31:0] DATA_ZERO = 32'h00000000;

  // method codes: 0 lim1 only, 1 lim1 + gated lim2, 2 lim1 + cmd both ways,
  // 3 lim1 + gated cmd, 4 lim1 + gated lim2 + gated cmd
  localparam logic [2:0] METH_LIM1 = 3'h0;
  localparam logic [2:0] METH_LIM2_GATED = 3'h1;
  localparam logic [2:0] METH_CMD = 3'h2;
  localparam logic [2:0] METH_CMD_GATED = 3'h3;
  localparam logic [2:0] METH_BOTH_GATED = 3'h4;

  typedef struct packed {
    logic [LIM_W-1:0] fwd;
    logic [LIM_W-1:0] rev;
  } lim_pair_t;

  typedef struct packed {
    logic trial;
    logic speed_or_torque;
  } mode_t;
endpackage

// *** bench/torque_limit_asserts.sv ***
// Purpose: port checks of the torque limit selector
// Assumes: clk_en held high, motor maximum left at reset
// Notes: limit stability checks wait for the input synchronisers to fill
`timescale 1ns/1ns
module torque_limit_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // limit path
  input wire logic fwd_limit_pin,
  input wire logic rev_limit_pin,
  input wire logic [torque_limit_pkg::IO_W-1:0] cmd_io_field,
  input wire logic signed [torque_limit_pkg::LIM_W-1:0] cmd_torque_limit,
  input wire torque_limit_pkg::mode_t op_mode,
  input wire torque_limit_pkg::lim_pair_t active_limit
);
  logic [3:0] up;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // warm-up counter: the outputs move from zero for a few edges after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up <= 4'h0;
    else if (!up[3]) up <= up + 4'h1;
  end
  sequence pins_still;
    (up[3] && !psel && $stable(fwd_limit_pin) && $stable(rev_limit_pin) && $stable(cmd_io_field))[*4];
  endsequence
  chk_ready_after_setup: assert property (psel && !penable |=> pready ##1 !pready) else $error("no single ready");
  chk_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_rdata_idle_zero: assert property (!pready |-> prdata == 32'h00000000) else $error("read data not idle");
  chk_fwd_max: assert property (active_limit.fwd <= 16'h012C) else $error("forward over maximum");
  chk_rev_max: assert property (active_limit.rev <= 16'h012C) else $error("reverse over maximum");
  chk_limit_stable: assert property ((pins_still and ($stable(op_mode) && $stable(cmd_torque_limit))[*4])
    |-> $stable(active_limit)) else $error("limit moved on still inputs");
  chk_trial_ignores: assert property ((pins_still and (op_mode == 2'h3)[*4]) |-> $stable(active_limit))
    else $error("command limit used in trial");
endmodule
bind torque_limit_selector torque_limit_asserts torque_limit_asserts_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fwd_limit_pin(fwd_limit_pin), .rev_limit_pin(rev_limit_pin), .cmd_io_field(cmd_io_field),
  .cmd_torque_limit(cmd_torque_limit), .op_mode(op_mode), .active_limit(active_limit));

// *** bench/host_cmd_model.sv ***
// Purpose: host controller side of the cyclic command frame
// Assumes: fields change just after a rising edge
// Notes: a frame stands until the next send
`timescale 1ns/1ns
module host_cmd_model (
  // clock
  input wire logic pclk,
  // command frame
  output logic [torque_limit_pkg::IO_W-1:0] cmd_io_field,
  output logic signed [torque_limit_pkg::LIM_W-1:0] cmd_torque_limit,
  output torque_limit_pkg::mode_t op_mode
);
  initial begin
    cmd_io_field = 16'h0000;
    cmd_torque_limit = 16'h0000;
    op_mode = 2'h0;
  end
  task automatic send(input logic [1:0] sel, input logic [15:0] lim, input logic [1:0] mode);
    @(posedge pclk);
    cmd_io_field <= {14'h0000, sel};
    cmd_torque_limit <= lim;
    op_mode <= mode;
  endtask
endmodule

// *** bench/testbench.sv ***
// Purpose: self-checking bench of the torque limit selector
// Assumes: clk_en held high, motor maximum left at reset
// Notes: active limits are read back over apb
`timescale 1ns/1ns
module testbench;
  logic pclk, presetn, psel, penable, pwrite, fwd_limit_pin, rev_limit_pin, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] io, cl;
  logic signed [15:0] tl;
  torque_limit_pkg::mode_t om;
  torque_limit_pkg::lim_pair_t act;
  logic [32:0] exp_q[$];
  logic [15:0] rst [6] = '{16'h0000, 16'h0320, 16'h0320, 16'h0064, 16'h0064, 16'h012C};
  logic [15:0] lv [4];
  logic [5:0] ctl;
  logic [1:0] pin, sel, md;
  int n_fail = 0, cmp_count = 0, seed = 97204;
  torque_limit_selector torque_limit_selector_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fwd_limit_pin(fwd_limit_pin), .rev_limit_pin(rev_limit_pin),
    .cmd_io_field(io), .cmd_torque_limit(tl), .op_mode(om), .active_limit(act));
  host_cmd_model host_cmd_model_inst (.pclk(pclk), .cmd_io_field(io), .cmd_torque_limit(tl), .op_mode(om));
  function automatic logic [15:0] pick(logic [15:0] l1, logic [15:0] l2, logic s, logic mp);
    logic [15:0] r, mag;
    logic en;
    r = l1;
    mag = (cl == 16'h8000) ? 16'h7FFF : (cl[15] ? -cl : cl);
    if ((ctl[2:0] == 3'h1 || ctl[2:0] == 3'h4) && s && l2 < r) r = l2;
    en = ctl[2:0] == 3'h2 || ((ctl[2:0] == 3'h3 || ctl[2:0] == 3'h4) && s && mp);
    if (en && md != 2'h3 && mag < r) r = mag;
    if (r > 16'h012C) r = 16'h012C;
    return r;
  endfunction
  task automatic compare(input string what, input logic [32:0] x, input logic [32:0] s);
    cmp_count++;
    if (s !== x) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
    if (!w) exp_q.push_back(x);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look at the ready pulse where it has settled, then finish on the edge that samples it
    do @(negedge pclk); while (pready !== 1'b1);
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) compare("apb read", exp_q.pop_front(), {pslverr, prdata});
  end
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // budget: about 1400 cycles of traffic, limit set well above it
  initial begin
    #500000;
    n_fail++;
    complete_run;
  end
  initial begin
    {presetn, psel, penable, pwrite, fwd_limit_pin, rev_limit_pin, paddr, pwdata} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst[i]) apb(1'b0, 12'(i * 4), 32'h00000000, {17'h00000, rst[i]});
    apb(1'b0, 12'h01C, 32'h00000000, {1'b0, 32'h012C012C});
    apb(1'b0, 12'h020, 32'h00000000, {1'b1, 32'h00000000});
    $display("test reset values done");
    repeat (40) begin
      foreach (lv[i]) begin
        lv[i] = 16'($random(seed) & 32'h1FF);
        apb(1'b1, 12'(4 + i * 4), {16'h0000, lv[i]}, 33'h000000000);
      end
      ctl = 6'($random(seed));
      apb(1'b1, 12'h000, {26'h0000000, ctl}, 33'h000000000);
      {pin, sel, md} = 6'($random(seed));
      fwd_limit_pin <= pin[0];
      rev_limit_pin <= pin[1];
      cl = 16'($random(seed));
      host_cmd_model_inst.send(sel, cl, md);
      repeat (5) @(posedge pclk);
      cl = 16'($random(seed));
      host_cmd_model_inst.send(sel, cl, md);
      repeat (5) @(posedge pclk);
      apb(1'b0, 12'h01C, 32'h00000000, {1'b0, pick(lv[0], lv[2], (pin[0] & ctl[4]) | sel[0], ctl[4]),
        pick(lv[1], lv[3], (pin[1] & ctl[5]) | sel[1], ctl[5])});
      apb(1'b0, 12'h018, 32'h00000000, {30'h00000000, md != 2'h3, (pin[1] & ctl[5]) | sel[1],
        (pin[0] & ctl[4]) | sel[0]});
    end
    $display("test random limits done");
    repeat (3) @(posedge pclk);
    complete_run;
  end
endmodule
